// [include/cals_map.vh]
// Opcode codes, condition-code bit positions and write-only read value for the ALU
`ifndef CALS_MAP_VH
`define CALS_MAP_VH
`define CALS_OP_ADD      5'h00
`define CALS_OP_SUB      5'h01
`define CALS_OP_ADDC     5'h02
`define CALS_OP_SUBC     5'h03
`define CALS_OP_INC      5'h04
`define CALS_OP_DECR     5'h05
`define CALS_OP_ADDS     5'h06
`define CALS_OP_SUBK     5'h07
`define CALS_OP_DADD     5'h08
`define CALS_OP_DSUB     5'h09
`define CALS_OP_MUL      5'h0a
`define CALS_OP_DIV      5'h0b
`define CALS_OP_COMP     5'h0c
`define CALS_OP_NEG      5'h0d
`define CALS_OP_AND      5'h0e
`define CALS_OP_OR       5'h0f
`define CALS_OP_XOR      5'h10
`define CALS_OP_NOT      5'h11
`define CALS_OP_ASL      5'h12
`define CALS_OP_ASR      5'h13
`define CALS_OP_LSL      5'h14
`define CALS_OP_LSR      5'h15
`define CALS_OP_ROL      5'h16
`define CALS_OP_ROR      5'h17
`define CALS_OP_RCL      5'h18
`define CALS_OP_RCR      5'h19
`define CALS_OP_BITCLR   5'h1a
`define CALS_FLAG_C      0
`define CALS_FLAG_V      1
`define CALS_FLAG_Z      2
`define CALS_FLAG_N      3
`define CALS_FLAG_H      5
`define CALS_WO_READ     8'hff
`define CALS_FLAG_RESET  8'h80
`define CALS_DIV_CYCLES  4'h8
`endif

// [src/cals_alu.v]
// Arithmetic, logic and shift unit with condition-code update
`timescale 1ns/1ps
// Contract
// - Add/sub on byte or word; immediates add only; word needs two registers
// - Add/sub with carry on byte data, register or immediate source
// - Increment and decrement change a byte register by exactly one
// - Address add/sub on word registers by constant one or two
// - Decimal adjust corrects byte result into packed BCD using flags
// - Unsigned multiply 8x8 gives 16-bit product in destination
// - Unsigned divide 16/8 returns quotient low, remainder high
// - Compare subtracts, stores nothing, updates flags; word compares registers only
// - Negate replaces byte with zero minus value
// - AND, OR, XOR combine byte with register or immediate
// - Invert replaces byte with its one's complement
// - Arithmetic shifts one place; right shift keeps the sign bit
// - Logical shifts one place, vacated bit filled with zero
// - Plain rotates wrap the outgoing bit to the other end
// - Carry rotates treat carry as ninth bit
// - Bit clear reads whole byte, clears bit, writes whole byte back
`include "cals_map.vh"
module cals_alu (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        op_valid,
  input  wire [4:0]  op_code,
  input  wire        op_word,
  input  wire        op_imm,
  input  wire        op_two,
  input  wire [2:0]  op_bit,
  input  wire        mem_wo,
  input  wire [15:0] rd_val,
  input  wire [15:0] rs_val,
  input  wire [7:0]  imm_val,
  output wire        op_ready,
  output reg  [15:0] res_reg,
  output reg         res_we_reg,
  output reg         res_word_reg,
  output reg         done_reg,
  output reg         illegal_reg,
  output reg  [7:0]  condition_code_reg
);
  localparam ST_IDLE = 1'b0;
  localparam ST_DIV  = 1'b1;
  reg        state_reg;
  reg [3:0]  cnt_reg;
  reg [15:0] rem_reg;
  reg [7:0]  quo_reg;
  reg [7:0]  dvs_reg;
  reg [15:0] res_next;
  reg        we_next;
  reg        wd_next;
  reg        bad_next;
  reg [7:0]  condition_code_next;
  reg [16:0] t17;
  reg [8:0]  t9;
  reg [7:0]  a8;
  reg [7:0]  b8;
  reg [7:0]  adj;
  reg        cin;
  reg        c;
  reg [8:0]  trial;

  // Ready drops for the whole divide; requests then are ignored
  assign op_ready = (state_reg == ST_IDLE);

  always @* begin
    a8 = rd_val[7:0];
    b8 = op_imm ? imm_val : rs_val[7:0];
    cin = condition_code_reg[`CALS_FLAG_C];
    c = cin;
    t9 = 9'h000;
    t17 = 17'h00000;
    adj = 8'h00;
    res_next = rd_val;
    we_next = 1'b1;
    wd_next = 1'b0;
    bad_next = 1'b0;
    condition_code_next = condition_code_reg;
    case (op_code)
      `CALS_OP_ADD, `CALS_OP_SUB, `CALS_OP_COMP: begin
        if ((op_word && op_imm) || (op_code != `CALS_OP_ADD && op_imm && op_word)) begin
          bad_next = 1'b1;
        end else if (op_code == `CALS_OP_SUB && op_imm) begin
          bad_next = 1'b1;
        end
        if (op_word) begin
          if (op_code == `CALS_OP_ADD)
            t17 = {1'b0, rd_val} + {1'b0, rs_val};
          else
            t17 = {1'b0, rd_val} - {1'b0, rs_val};
          res_next = t17[15:0];
          wd_next = 1'b1;
          condition_code_next[`CALS_FLAG_N] = t17[15];
          condition_code_next[`CALS_FLAG_Z] = (t17[15:0] == 16'h0000);
          condition_code_next[`CALS_FLAG_C] = t17[16];
          condition_code_next[`CALS_FLAG_V] = (op_code == `CALS_OP_ADD) ?
            (rd_val[15] == rs_val[15]) && (t17[15] != rd_val[15]) :
            (rd_val[15] != rs_val[15]) && (t17[15] != rd_val[15]);
        end else begin
          if (op_code == `CALS_OP_ADD)
            t9 = {1'b0, a8} + {1'b0, b8};
          else
            t9 = {1'b0, a8} - {1'b0, b8};
          res_next = {rd_val[15:8], t9[7:0]};
          condition_code_next[`CALS_FLAG_N] = t9[7];
          condition_code_next[`CALS_FLAG_Z] = (t9[7:0] == 8'h00);
          condition_code_next[`CALS_FLAG_C] = t9[8];
          condition_code_next[`CALS_FLAG_H] = (op_code == `CALS_OP_ADD) ?
            (({1'b0, a8[3:0]} + {1'b0, b8[3:0]}) > 5'h0f) : (a8[3:0] < b8[3:0]);
          condition_code_next[`CALS_FLAG_V] = (op_code == `CALS_OP_ADD) ?
            (a8[7] == b8[7]) && (t9[7] != a8[7]) :
            (a8[7] != b8[7]) && (t9[7] != a8[7]);
        end
        if (op_code == `CALS_OP_COMP || bad_next)
          we_next = 1'b0;
      end
      `CALS_OP_ADDC, `CALS_OP_SUBC: begin
        if (op_code == `CALS_OP_ADDC)
          t9 = {1'b0, a8} + {1'b0, b8} + {8'h00, cin};
        else
          t9 = {1'b0, a8} - {1'b0, b8} - {8'h00, cin};
        res_next = {rd_val[15:8], t9[7:0]};
        condition_code_next[`CALS_FLAG_N] = t9[7];
        // Zero only cleared, so multi-byte chains test the whole value
        if (t9[7:0] != 8'h00)
          condition_code_next[`CALS_FLAG_Z] = 1'b0;
        condition_code_next[`CALS_FLAG_C] = t9[8];
        condition_code_next[`CALS_FLAG_V] = (op_code == `CALS_OP_ADDC) ?
          (a8[7] == b8[7]) && (t9[7] != a8[7]) :
          (a8[7] != b8[7]) && (t9[7] != a8[7]);
        if (op_word) begin
          bad_next = 1'b1;
          we_next = 1'b0;
        end
      end
      `CALS_OP_INC, `CALS_OP_DECR, `CALS_OP_NEG: begin
        if (op_code == `CALS_OP_INC)
          t9 = {1'b0, a8} + 9'h001;
        else if (op_code == `CALS_OP_DECR)
          t9 = {1'b0, a8} - 9'h001;
        else
          t9 = 9'h000 - {1'b0, a8};
        res_next = {rd_val[15:8], t9[7:0]};
        condition_code_next[`CALS_FLAG_N] = t9[7];
        condition_code_next[`CALS_FLAG_Z] = (t9[7:0] == 8'h00);
        condition_code_next[`CALS_FLAG_V] = (op_code == `CALS_OP_INC) ? (a8 == 8'h7f) :
                                            (a8 == 8'h80);
        if (op_code == `CALS_OP_NEG)
          condition_code_next[`CALS_FLAG_C] = (a8 != 8'h00);
      end
      `CALS_OP_ADDS, `CALS_OP_SUBK: begin
        wd_next = 1'b1;
        // Pointer arithmetic leaves flags untouched
        if (op_code == `CALS_OP_ADDS)
          res_next = rd_val + (op_two ? 16'h0002 : 16'h0001);
        else
          res_next = rd_val - (op_two ? 16'h0002 : 16'h0001);
      end
      `CALS_OP_DADD, `CALS_OP_DSUB: begin
        if (op_code == `CALS_OP_DADD) begin
          if (condition_code_reg[`CALS_FLAG_H] || a8[3:0] > 4'h9)
            adj[3:0] = 4'h6;
          if (cin || a8 > 8'h99) begin
            adj[7:4] = 4'h6;
            c = 1'b1;
          end
          res_next = {rd_val[15:8], a8 + adj};
        end else begin
          if (condition_code_reg[`CALS_FLAG_H])
            adj[3:0] = 4'h6;
          if (cin)
            adj[7:4] = 4'h6;
          res_next = {rd_val[15:8], a8 - adj};
        end
        condition_code_next[`CALS_FLAG_C] = c;
        condition_code_next[`CALS_FLAG_N] = res_next[7];
        condition_code_next[`CALS_FLAG_Z] = (res_next[7:0] == 8'h00);
      end
      `CALS_OP_MUL: begin
        res_next = {8'h00, a8} * {8'h00, rs_val[7:0]};
        wd_next = 1'b1;
      end
      `CALS_OP_DIV: begin
        we_next = 1'b0;
        wd_next = 1'b1;
      end
      `CALS_OP_AND, `CALS_OP_OR, `CALS_OP_XOR, `CALS_OP_NOT: begin
        case (op_code)
          `CALS_OP_AND: res_next[7:0] = a8 & b8;
          `CALS_OP_OR:  res_next[7:0] = a8 | b8;
          `CALS_OP_XOR: res_next[7:0] = a8 ^ b8;
          default:      res_next[7:0] = ~a8;
        endcase
        condition_code_next[`CALS_FLAG_N] = res_next[7];
        condition_code_next[`CALS_FLAG_Z] = (res_next[7:0] == 8'h00);
        condition_code_next[`CALS_FLAG_V] = 1'b0;
      end
      `CALS_OP_ASL, `CALS_OP_ASR, `CALS_OP_LSL, `CALS_OP_LSR,
      `CALS_OP_ROL, `CALS_OP_ROR, `CALS_OP_RCL, `CALS_OP_RCR: begin
        case (op_code)
          `CALS_OP_ASL: res_next[7:0] = {a8[6:0], 1'b0};
          `CALS_OP_ASR: res_next[7:0] = {a8[7], a8[7:1]};
          `CALS_OP_LSL: res_next[7:0] = {a8[6:0], 1'b0};
          `CALS_OP_LSR: res_next[7:0] = {1'b0, a8[7:1]};
          `CALS_OP_ROL: res_next[7:0] = {a8[6:0], a8[7]};
          `CALS_OP_ROR: res_next[7:0] = {a8[0], a8[7:1]};
          `CALS_OP_RCL: res_next[7:0] = {a8[6:0], cin};
          default:      res_next[7:0] = {cin, a8[7:1]};
        endcase
        c = (op_code == `CALS_OP_ASL || op_code == `CALS_OP_LSL ||
             op_code == `CALS_OP_ROL || op_code == `CALS_OP_RCL) ? a8[7] : a8[0];
        condition_code_next[`CALS_FLAG_C] = c;
        condition_code_next[`CALS_FLAG_N] = res_next[7];
        condition_code_next[`CALS_FLAG_Z] = (res_next[7:0] == 8'h00);
        condition_code_next[`CALS_FLAG_V] = (op_code == `CALS_OP_ASL) ? (a8[7] ^ a8[6]) : 1'b0;
      end
      `CALS_OP_BITCLR: begin
        // Write-only targets read all ones, so other bits come back set
        b8 = mem_wo ? `CALS_WO_READ : a8;
        res_next = {rd_val[15:8], b8 & ~(8'h01 << op_bit)};
      end
      default: begin
        bad_next = 1'b1;
        we_next = 1'b0;
      end
    endcase
  end

  // Restoring divide, one quotient bit per cycle
  always @* begin
    trial = {1'b0, rem_reg[14:7]} - {1'b0, dvs_reg};
  end

  always @(posedge clk_sys) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      rem_reg <= 16'h0000;
      quo_reg <= 8'h00;
      dvs_reg <= 8'h00;
      res_reg <= 16'h0000;
      res_we_reg <= 1'b0;
      res_word_reg <= 1'b0;
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      condition_code_reg <= `CALS_FLAG_RESET;
    end else begin
      done_reg <= 1'b0;
      res_we_reg <= 1'b0;
      illegal_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (op_valid && op_code == `CALS_OP_DIV) begin
            rem_reg <= rd_val;
            dvs_reg <= rs_val[7:0];
            quo_reg <= 8'h00;
            cnt_reg <= `CALS_DIV_CYCLES;
            state_reg <= ST_DIV;
            // Zero divisor gives an all-ones quotient; callers test the zero flag
            condition_code_reg[`CALS_FLAG_Z] <= (rs_val[7:0] == 8'h00);
          end else if (op_valid) begin
            // Held when nothing is written back, so a compare keeps the last result
            if (we_next)
              res_reg <= res_next;
            res_we_reg <= we_next;
            res_word_reg <= wd_next;
            illegal_reg <= bad_next;
            done_reg <= 1'b1;
            if (!bad_next)
              condition_code_reg <= condition_code_next;
          end
        end
        ST_DIV: begin
          // Upper dividend byte must be below the divisor or the quotient overflows
          if (!trial[8] || rem_reg[15]) begin
            rem_reg <= {trial[7:0], rem_reg[6:0], 1'b0};
            quo_reg <= {quo_reg[6:0], 1'b1};
          end else begin
            rem_reg <= {rem_reg[14:0], 1'b0};
            quo_reg <= {quo_reg[6:0], 1'b0};
          end
          cnt_reg <= cnt_reg - 4'h1;
          if (cnt_reg == 4'h1) begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
            res_word_reg <= 1'b1;
            res_we_reg <= 1'b1;
            if (!trial[8] || rem_reg[15])
              res_reg <= {trial[7:0], quo_reg[6:0], 1'b1};
            else
              res_reg <= {rem_reg[14:7], quo_reg[6:0], 1'b0};
            condition_code_reg[`CALS_FLAG_N] <= quo_reg[6];
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// [verification/cals_regfile.sv]
// Register file model that takes the unit's write-backs
`timescale 1ns/1ps
module cals_regfile (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        res_we_reg,
  input  wire logic [15:0] res_reg,
  output logic      [15:0] wb_val,
  output logic      [7:0]  wb_cnt
);
  // Whole word written back on each pulse, never a partial merge
  always @(posedge clk_sys) begin
    if (!nrst) begin
      wb_val <= 16'h0000;
      wb_cnt <= 8'h00;
    end else if (res_we_reg) begin
      wb_val <= res_reg;
      wb_cnt <= wb_cnt + 8'h01;
    end
  end
endmodule

// [verification/cals_monitor.sv]
// Concurrent checks on the arithmetic unit ports
`timescale 1ns/1ps
`include "cals_map.vh"
module cals_monitor (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        op_valid,
  input wire logic [4:0]  op_code,
  input wire logic        op_word,
  input wire logic        op_imm,
  input wire logic        op_two,
  input wire logic [2:0]  op_bit,
  input wire logic        mem_wo,
  input wire logic [15:0] rd_val,
  input wire logic [15:0] rs_val,
  input wire logic [7:0]  imm_val,
  input wire logic        op_ready,
  input wire logic [15:0] res_reg,
  input wire logic        res_we_reg,
  input wire logic        res_word_reg,
  input wire logic        done_reg,
  input wire logic        illegal_reg,
  input wire logic [7:0]  condition_code_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  wire take = op_valid && op_ready;
  reset_values_a: assert property (disable iff (1'b0)
    !nrst |=> condition_code_reg == 8'h80 && !done_reg)
    else $error("reset state wrong");
  done_next_a: assert property (take && op_code != `CALS_OP_DIV |=> done_reg)
    else $error("done not one cycle after request");
  div_timing_a: assert property (take && op_code == `CALS_OP_DIV
    |=> (!op_ready)[*8] ##1 (done_reg && op_ready))
    else $error("divide timing wrong");
  illegal_quiet_a: assert property (illegal_reg
    |-> done_reg && !res_we_reg && $stable(condition_code_reg))
    else $error("illegal form changed state");
  comp_no_write_a: assert property (take && op_code == `CALS_OP_COMP |=> !res_we_reg)
    else $error("compare wrote a result");
  inc_by_one_a: assert property (take && op_code == `CALS_OP_INC
    |=> res_reg[7:0] == $past(rd_val[7:0]) + 8'h01)
    else $error("increment wrong");
  adds_const_a: assert property (take && op_code == `CALS_OP_ADDS
    |=> res_reg == $past(rd_val) + ($past(op_two) ? 16'h0002 : 16'h0001))
    else $error("address add wrong");
  mul_product_a: assert property (take && op_code == `CALS_OP_MUL
    |=> res_word_reg && res_reg == $past(rd_val[7:0]) * $past(rs_val[7:0]))
    else $error("product wrong");
  neg_twos_a: assert property (take && op_code == `CALS_OP_NEG
    |=> res_reg[7:0] == 8'h00 - $past(rd_val[7:0]))
    else $error("negate wrong");
  bitclr_whole_a: assert property (take && op_code == `CALS_OP_BITCLR |=> res_reg[7:0] ==
    (($past(mem_wo) ? 8'hff : $past(rd_val[7:0])) & ~(8'h01 << $past(op_bit))))
    else $error("bit clear wrong");
endmodule
bind cals_alu cals_monitor u_mon (.*);

// [verification/testbench.sv]
// Self-checking bench for the arithmetic unit
`timescale 1ns/1ps
module testbench;
  logic clk_sys, nrst, op_valid, op_word, op_imm, op_two, mem_wo;
  logic [4:0] op_code;
  logic [2:0] op_bit;
  logic [15:0] rd_val, rs_val, res_reg, wb_val;
  logic [7:0] imm_val, condition_code_reg, wb_cnt;
  logic op_ready, res_we_reg, res_word_reg, done_reg, illegal_reg;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_wr = 0;
  logic [75:0] t [0:32];
  cals_alu dut (.clk_sys(clk_sys), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
    .op_word(op_word), .op_imm(op_imm), .op_two(op_two), .op_bit(op_bit), .mem_wo(mem_wo),
    .rd_val(rd_val), .rs_val(rs_val), .imm_val(imm_val), .op_ready(op_ready),
    .res_reg(res_reg), .res_we_reg(res_we_reg), .res_word_reg(res_word_reg),
    .done_reg(done_reg), .illegal_reg(illegal_reg), .condition_code_reg(condition_code_reg));
  cals_regfile u_rf (.clk_sys(clk_sys), .nrst(nrst), .res_we_reg(res_we_reg),
    .res_reg(res_reg), .wb_val(wb_val), .wb_cnt(wb_cnt));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  task fail(input string s);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, s);
  endtask
  task end_of_test();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Row: op, mode {wo,bit,0,word,imm,two}, rd, rs or immediate, result, status {0,word,illegal,write}, flag mask, flags
  task go(input logic [75:0] r);
    int k;
    @(negedge clk_sys);
    {op_code, mem_wo, op_bit, op_word, op_imm, op_two} = {r[72:68], r[67:64], r[62:60]};
    rd_val = r[59:44];
    rs_val = r[61] ? ~r[43:28] : r[43:28];
    imm_val = r[35:28];
    op_valid = 1'b1;
    k = 0;
    @(negedge clk_sys);
    op_valid = 1'b0;
    while (done_reg !== 1'b1 && k < 12) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 12) begin
      fail("no completion");
      end_of_test();
    end
    samples_checked += 5;
    n_wr += r[8];
    if (res_reg !== r[27:12]) fail("result mismatch");
    if (res_we_reg !== r[8]) fail("write strobe mismatch");
    if (illegal_reg !== r[9]) fail("illegal flag mismatch");
    if (res_word_reg !== r[10]) fail("word flag mismatch");
    if ((condition_code_reg[3:0] & r[7:4]) !== r[3:0]) fail("flag mismatch");
  endtask
  initial begin
    {nrst, op_valid, op_code, op_word, op_imm, op_two, op_bit, mem_wo} = 13'h0000;
    {rd_val, rs_val, imm_val} = 40'h0;
    t[0] = 76'h00_00_a5ff_0001_a500_1_d_5;
    t[1] = 76'h02_00_0010_0020_0031_1_1_0;
    t[2] = 76'h00_04_1234_1111_2345_5_f_0;
    t[3] = 76'h00_02_0010_0005_0015_1_1_0;
    t[4] = 76'h01_02_0050_0010_0015_2_0_0;
    t[5] = 76'h03_02_0050_0010_0040_1_1_0;
    t[6] = 76'h04_00_00ff_0000_0000_1_4_4;
    t[7] = 76'h05_00_0000_0000_00ff_1_c_8;
    t[8] = 76'h06_01_fffe_0000_0000_5_0_0;
    t[9] = 76'h07_00_0000_0000_ffff_5_0_0;
    t[10] = 76'h00_00_0015_0027_003c_1_1_0;
    t[11] = 76'h08_00_003c_0000_0042_1_0_0;
    t[12] = 76'h01_00_0042_0015_002d_1_1_0;
    t[13] = 76'h09_00_002d_0000_0027_1_0_0;
    t[14] = 76'h0a_00_00ff_00ff_fe01_5_0_0;
    t[15] = 76'h0b_00_0123_0010_0312_5_0_0;
    t[16] = 76'h0c_00_0005_0005_0312_0_4_4;
    t[17] = 76'h0c_04_1234_1235_0312_4_d_9;
    t[18] = 76'h0d_00_0080_0000_0080_1_3_3;
    t[19] = 76'h0e_00_00f0_003c_0030_1_0_0;
    t[20] = 76'h0f_02_00f0_000f_00ff_1_0_0;
    t[21] = 76'h10_00_00ff_000f_00f0_1_0_0;
    t[22] = 76'h11_00_0055_0000_00aa_1_0_0;
    t[23] = 76'h12_00_0041_0000_0082_1_1_0;
    t[24] = 76'h13_00_0081_0000_00c0_1_1_1;
    t[25] = 76'h14_00_00c0_0000_0080_1_1_1;
    t[26] = 76'h15_00_0081_0000_0040_1_1_1;
    t[27] = 76'h16_00_0081_0000_0003_1_1_1;
    t[28] = 76'h17_00_0001_0000_0080_1_1_1;
    t[29] = 76'h18_00_0080_0000_0001_1_1_1;
    t[30] = 76'h19_00_0002_0000_0081_1_1_0;
    t[31] = 76'h1a_90_003f_0000_00fd_1_0_0;
    t[32] = 76'h1a_70_00ff_0000_007f_1_0_0;
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    // Rows run in order: carry and half-carry chain from one row into the next
    for (int i = 0; i < 33; i++) go(t[i]);
    repeat (2) @(negedge clk_sys);
    samples_checked += 2;
    if (wb_cnt !== n_wr[7:0]) fail("write-back count mismatch");
    if (wb_val !== 16'h007f) fail("write-back value mismatch");
    // Request while divide is busy must be ignored
    go(t[15]);
    @(negedge clk_sys);
    {op_code, op_valid} = {5'h0b, 1'b1};
    @(negedge clk_sys);
    op_code = 5'h04;
    @(negedge clk_sys);
    op_valid = 1'b0;
    repeat (12) @(negedge clk_sys);
    samples_checked++;
    if (wb_cnt !== n_wr[7:0] + 8'h01) fail("busy request not ignored");
    nrst = 1'b0;
    @(negedge clk_sys);
    nrst = 1'b1;
    samples_checked++;
    if ({condition_code_reg, res_reg, op_ready, done_reg} !== 26'h2000002)
      fail("reset state mismatch");
    end_of_test();
  end
endmodule
